//--- fsw_regs.vh
`ifndef FSW_REGS_VH
`define FSW_REGS_VH
// Internal-memory indices of the user output limits
`define FSW_ADDR_CUR_LIMIT   8'h64
`define FSW_ADDR_VOLT_LIMIT  8'h65
// Extra control and status words (all read back; the fault-reset bit reads 0)
`define FSW_ADDR_CTRL        8'h66
`define FSW_ADDR_TC_MIN      8'h67
`define FSW_ADDR_TC_MAX      8'h68
`define FSW_ADDR_WAVE_PERIOD 8'h69
`define FSW_ADDR_WAVE_COUNT  8'h6A
`define FSW_ADDR_STATUS      8'h6B
// Control word bit positions
`define FSW_CTRL_OUT_EN      0
`define FSW_CTRL_TC_EN       1
`define FSW_CTRL_WAVE_RUN    2
`define FSW_CTRL_WAVE_CV     3
`define FSW_CTRL_FAULT_RST   4
// Fault status bit positions
`define FSW_F_INPUT_OC       0
`define FSW_F_XDCR           1
`define FSW_F_OVERPOWER      2
`define FSW_F_OUT_CUR        3
`define FSW_F_OUT_VOLT       4
`define FSW_F_THERMO         5
`define FSW_F_FAN            6
`define FSW_NUM_FAULTS       7
// Reset values of the limit words
`define FSW_LIMIT_RESET      32'hFFFF_FFFF
`define FSW_TC_MIN_RESET     32'h0000_0000
// Timing: clock rate, over-power intervals, least waveform step
`define FSW_CLK_HZ           250000000
`define FSW_LONG_S           120
`define FSW_SHORT_S          1
`define FSW_STEP_NS          10000
`define FSW_CLK_NS           4
`endif

//--- fsw_fault_supervisor.v
`timescale 1ns/1ns
`include "fsw_regs.vh"
// Operation
// - Input current compared with a fixed model threshold, not software writable.
// - Input overcurrent sets a latched fault and drops output enable.
// - Output stays off after input overcurrent until fault status reset.
// - Transducer health watched continuously; malfunction faults and disables output.
// - Transducer fault clears only after its cause has gone.
// - Power below rated plus lower margin runs without limit.
// - Power between margins is timed; fault after the long interval.
// - Power at or above upper margin faults after the short interval.
// - Over-power uses absolute power, source and sink alike.
// - Output off when current or voltage exceeds the user limit.
// - Current limit at address 100, voltage limit at 101, user writable.
// - Thermocouple fault exists only with option fitted, acts only when enabled.
// - Enabled thermocouple fault trips below minimum or above maximum.
// - Any fan reporting a wrong state switches the output off.
// - Waveform sequencer runs in current or voltage mode, programmable count, period.
// - Waveform periods shorter than the least step are rejected.
module fsw_fault_supervisor #(
   parameter [39:0] LONG_CYCLES  = `FSW_LONG_S * `FSW_CLK_HZ,
   parameter [31:0] SHORT_CYCLES = `FSW_SHORT_S * `FSW_CLK_HZ,
   parameter [31:0] IN_OC_LIMIT  = 32'h7FFF_FFFF,
   parameter [31:0] RATED_POWER  = 32'h0000_05DC,
   parameter        TC_FITTED    = 1
) (
   input  wire        clk_sys,
   input  wire        reset,
   // Internal-memory port
   input  wire        mem_wr,
   input  wire [7:0]  mem_addr,
   input  wire [31:0] mem_wdata,
   output reg  [31:0] mem_rdata,
   // Power stage sensing
   input  wire [31:0] input_current,
   input  wire        output_current_transducer_ok,
   input  wire signed [31:0] output_power,
   input  wire [31:0] output_current_abs,
   input  wire [31:0] output_voltage,
   input  wire signed [31:0] thermo_temp,
   input  wire [3:0]  fan_ok,
   // Output enable and waveform
   output wire        output_enable,
   output wire [6:0]  fault_status,
   input  wire [31:0] wave_point,
   output reg  [9:0]  wave_index,
   output reg  [31:0] wave_setpoint,
   output reg         wave_cv_mode,
   output reg         wave_step
);

   // Least waveform step in cycles, rounded up
   localparam [31:0] STEP_CYCLES = (`FSW_STEP_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS;

   reg  [31:0] cur_limit_q;
   reg  [31:0] volt_limit_q;
   reg  [31:0] tc_min_q;
   reg  [31:0] tc_max_q;
   reg  [31:0] wave_period_q;
   reg  [9:0]  wave_count_q;
   reg         out_req_q;
   reg         tc_en_q;
   reg         wave_run_q;
   reg         period_reject_q;
   reg  [6:0]  fault_q;
   reg  [39:0] long_cnt_q;
   reg  [31:0] short_cnt_q;
   reg  [31:0] wave_cnt_q;
   wire [31:0] power_abs;
   wire [31:0] lower_band;
   wire [31:0] upper_band;
   wire        band_mid;
   wire        band_high;
   wire        rst_pulse;
   wire [6:0]  cause;

   // Absolute power so sinking counts like sourcing
   assign power_abs  = output_power[31] ? (~output_power + 32'h0000_0001)
                                        : output_power;
   // 102 % and 105 % of rating
   assign lower_band = RATED_POWER + (RATED_POWER * 2) / 100;
   assign upper_band = RATED_POWER + (RATED_POWER * 5) / 100;
   assign band_high  = (power_abs >= upper_band);
   assign band_mid   = (power_abs >= lower_band) && !band_high;
   assign rst_pulse  = mem_wr && (mem_addr == `FSW_ADDR_CTRL) &&
                       mem_wdata[`FSW_CTRL_FAULT_RST];

   // Live causes of each fault
   assign cause[`FSW_F_INPUT_OC]  = (input_current > IN_OC_LIMIT);
   assign cause[`FSW_F_XDCR]      = !output_current_transducer_ok;
   assign cause[`FSW_F_OVERPOWER] = (long_cnt_q >= LONG_CYCLES) ||
                                    (short_cnt_q >= SHORT_CYCLES);
   assign cause[`FSW_F_OUT_CUR]   = (output_current_abs > cur_limit_q);
   assign cause[`FSW_F_OUT_VOLT]  = (output_voltage > volt_limit_q);
   assign cause[`FSW_F_THERMO]    = (TC_FITTED != 0) && tc_en_q &&
                                    ((thermo_temp < $signed(tc_min_q)) ||
                                     (thermo_temp > $signed(tc_max_q)));
   assign cause[`FSW_F_FAN]       = (fan_ok != 4'hF);

   assign fault_status  = fault_q;
   assign output_enable = out_req_q && (fault_q == 7'h00);

   // Register writes; a period below the least step is refused
   always @(posedge clk_sys) begin
      if (reset) begin
         cur_limit_q     <= `FSW_LIMIT_RESET;
         volt_limit_q    <= `FSW_LIMIT_RESET;
         tc_min_q        <= `FSW_TC_MIN_RESET;
         tc_max_q        <= 32'h7FFF_FFFF;
         wave_period_q   <= 32'h0000_0000;
         wave_count_q    <= 10'h000;
         out_req_q       <= 1'b0;
         tc_en_q         <= 1'b0;
         wave_cv_mode    <= 1'b0;
         period_reject_q <= 1'b0;
      end else if (mem_wr) begin
         if (mem_addr == `FSW_ADDR_CUR_LIMIT) begin
            cur_limit_q <= mem_wdata;
         end else if (mem_addr == `FSW_ADDR_VOLT_LIMIT) begin
            volt_limit_q <= mem_wdata;
         end else if (mem_addr == `FSW_ADDR_CTRL) begin
            out_req_q    <= mem_wdata[`FSW_CTRL_OUT_EN];
            tc_en_q      <= mem_wdata[`FSW_CTRL_TC_EN] && (TC_FITTED != 0);
            wave_cv_mode <= mem_wdata[`FSW_CTRL_WAVE_CV];
         end else if (mem_addr == `FSW_ADDR_TC_MIN) begin
            tc_min_q <= mem_wdata;
         end else if (mem_addr == `FSW_ADDR_TC_MAX) begin
            tc_max_q <= mem_wdata;
         end else if (mem_addr == `FSW_ADDR_WAVE_PERIOD) begin
            if (mem_wdata < STEP_CYCLES) begin
               period_reject_q <= 1'b1;
            end else begin
               wave_period_q   <= mem_wdata;
               period_reject_q <= 1'b0;
            end
         end else if (mem_addr == `FSW_ADDR_WAVE_COUNT) begin
            wave_count_q <= mem_wdata[9:0];
         end
      end
   end

   // Over-power timers restart whenever power leaves their band
   always @(posedge clk_sys) begin
      if (reset) begin
         long_cnt_q  <= 40'h00_0000_0000;
         short_cnt_q <= 32'h0000_0000;
      end else begin
         if (band_mid && (long_cnt_q < LONG_CYCLES)) begin
            long_cnt_q <= long_cnt_q + 40'h00_0000_0001;
         end else if (!band_mid) begin
            long_cnt_q <= 40'h00_0000_0000;
         end
         if (band_high && (short_cnt_q < SHORT_CYCLES)) begin
            short_cnt_q <= short_cnt_q + 32'h0000_0001;
         end else if (!band_high) begin
            short_cnt_q <= 32'h0000_0000;
         end
      end
   end

   // Sticky faults; a live cause wins over the reset
   genvar gi;
   generate
      for (gi = 0; gi < `FSW_NUM_FAULTS; gi = gi + 1) begin : g_fault
         always @(posedge clk_sys) begin
            if (reset) begin
               fault_q[gi] <= 1'b0;
            end else if (cause[gi]) begin
               fault_q[gi] <= 1'b1;
            end else if (rst_pulse) begin
               fault_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Waveform sequencer; halts on any fault so the stage sees no new setpoint
   always @(posedge clk_sys) begin
      if (reset) begin
         wave_run_q    <= 1'b0;
         wave_cnt_q    <= 32'h0000_0000;
         wave_index    <= 10'h000;
         wave_setpoint <= 32'h0000_0000;
         wave_step     <= 1'b0;
      end else begin
         wave_step <= 1'b0;
         if (mem_wr && (mem_addr == `FSW_ADDR_CTRL)) begin
            wave_run_q <= mem_wdata[`FSW_CTRL_WAVE_RUN] &&
                          (wave_period_q >= STEP_CYCLES) && (wave_count_q != 10'h000);
            wave_cnt_q <= 32'h0000_0000;
            wave_index <= 10'h000;
         end else if (wave_run_q && !output_enable) begin
            wave_run_q <= 1'b0;
         end else if (wave_run_q) begin
            if (wave_cnt_q >= wave_period_q - 32'h0000_0001) begin
               wave_cnt_q    <= 32'h0000_0000;
               wave_setpoint <= wave_point;
               wave_step     <= 1'b1;
               if (wave_index >= wave_count_q - 10'h001) begin
                  wave_index <= 10'h000;
               end else begin
                  wave_index <= wave_index + 10'h001;
               end
            end else begin
               wave_cnt_q <= wave_cnt_q + 32'h0000_0001;
            end
         end
      end
   end

   // Registered read-back
   always @(posedge clk_sys) begin
      if (reset) begin
         mem_rdata <= 32'h0000_0000;
      end else if (mem_addr == `FSW_ADDR_CUR_LIMIT) begin
         mem_rdata <= cur_limit_q;
      end else if (mem_addr == `FSW_ADDR_VOLT_LIMIT) begin
         mem_rdata <= volt_limit_q;
      end else if (mem_addr == `FSW_ADDR_CTRL) begin
         mem_rdata <= {27'h000_0000, 1'b0, wave_cv_mode, wave_run_q, tc_en_q, out_req_q};
      end else if (mem_addr == `FSW_ADDR_TC_MIN) begin
         mem_rdata <= tc_min_q;
      end else if (mem_addr == `FSW_ADDR_TC_MAX) begin
         mem_rdata <= tc_max_q;
      end else if (mem_addr == `FSW_ADDR_WAVE_PERIOD) begin
         mem_rdata <= wave_period_q;
      end else if (mem_addr == `FSW_ADDR_WAVE_COUNT) begin
         mem_rdata <= {22'h00_0000, wave_count_q};
      end else if (mem_addr == `FSW_ADDR_STATUS) begin
         mem_rdata <= {23'h00_0000, period_reject_q, output_enable, fault_q};
      end else begin
         mem_rdata <= 32'h0000_0000;
      end
   end

endmodule // fsw_fault_supervisor

//--- fsw_fault_supervisor_sva.sv
`timescale 1ns/1ns
// Pin-level watch on the supervisor; thresholds follow the bound parameters, except the step gap, fixed at 16'h09C4
module fsw_fault_supervisor_sva #(
   parameter [31:0] SHORT_CYCLES = 32'h0000_0032,
   parameter [31:0] IN_OC_LIMIT  = 32'h7FFF_FFFF,
   parameter [31:0] RATED_POWER  = 32'h0000_05DC
) (
   input logic               clk_sys,
   input logic               reset,
   input logic               mem_wr,
   input logic [7:0]         mem_addr,
   input logic [31:0]        mem_wdata,
   input logic [31:0]        mem_rdata,
   input logic [31:0]        input_current,
   input logic               output_current_transducer_ok,
   input logic signed [31:0] output_power,
   input logic [3:0]         fan_ok,
   input logic               output_enable,
   input logic [6:0]         fault_status,
   input logic               wave_step
);
   localparam [31:0] HI = RATED_POWER * 105 / 100;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [31:0] p_abs;
   logic [15:0] gap_q;
   logic [15:0] hi_q;
   wire         rst_wr = mem_wr && mem_addr == 8'h64 + 8'h02 && mem_wdata[4];
   // Magnitude, so sinking is judged like sourcing
   assign p_abs = output_power[31] ? -output_power : output_power;
   // Gap since the last step, and run length at or above the upper margin
   always @(posedge clk_sys) begin
      if (reset) begin
         gap_q <= 16'hFFFF;
         hi_q  <= 16'h0000;
      end else begin
         gap_q <= wave_step ? 16'h0001 : (gap_q == 16'hFFFF ? gap_q : gap_q + 16'h0001);
         hi_q  <= (p_abs >= HI) ? hi_q + 16'h0001 : 16'h0000;
      end
   end
   property p_inoc; input_current > IN_OC_LIMIT |=> fault_status[0]; endproperty
   a_inoc: assert property (p_inoc) else $error("input overcurrent not latched");
   property p_hold; fault_status[0] && !rst_wr |=> fault_status[0]; endproperty
   a_hold: assert property (p_hold) else $error("overcurrent bit dropped");
   property p_clr; rst_wr && input_current <= IN_OC_LIMIT |=> !fault_status[0]; endproperty
   a_clr: assert property (p_clr) else $error("bit kept without cause");
   property p_xdcr; !output_current_transducer_ok |=> fault_status[1] && !output_enable; endproperty
   a_xdcr: assert property (p_xdcr) else $error("transducer fault missed");
   property p_fan; fan_ok != 4'hF |=> fault_status[6]; endproperty
   a_fan: assert property (p_fan) else $error("fan fault missed");
   property p_oen; |fault_status |-> !output_enable; endproperty
   a_oen: assert property (p_oen) else $error("enable high with fault");
   property p_short; hi_q > SHORT_CYCLES + 4 |-> fault_status[2]; endproperty
   a_short: assert property (p_short) else $error("short overpower late");
   property p_gap; wave_step |-> gap_q >= 16'h09C4; endproperty
   a_gap: assert property (p_gap) else $error("steps too close");
   property p_unmap; !(mem_addr inside {[8'h64:8'h6B]}) |=> mem_rdata == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // fsw_fault_supervisor_sva
bind fsw_fault_supervisor fsw_fault_supervisor_sva #(.SHORT_CYCLES(SHORT_CYCLES),
   .IN_OC_LIMIT(IN_OC_LIMIT), .RATED_POWER(RATED_POWER)) i_sva (.clk_sys, .reset, .mem_wr,
   .mem_addr, .mem_wdata, .mem_rdata, .input_current, .output_current_transducer_ok,
   .output_power, .fan_ok, .output_enable, .fault_status, .wave_step);

//--- fsw_sensor_model.sv
`timescale 1ns/1ns
// Power stage sensors; each nonzero scene code puts one reading out of range
module fsw_sensor_model (
   input logic                clk_sys,
   input logic [2:0]          scene,
   input logic [9:0]          wave_index,
   output logic [31:0]        input_current,
   output logic               output_current_transducer_ok,
   output logic signed [31:0] output_power,
   output logic [31:0]        output_current_abs,
   output logic [31:0]        output_voltage,
   output logic signed [31:0] thermo_temp,
   output logic [3:0]         fan_ok,
   output logic [31:0]        wave_point
);
   // Readings settle one edge after the scene changes, like a real sampler
   always @(posedge clk_sys) begin
      input_current <= scene == 3'h1 ? 32'hFFFF_FFFF : 32'h0000_0100;
      output_current_transducer_ok <= scene != 3'h2;
      output_power <= scene == 3'h3 ? 32'h0000_0626 :
         scene == 3'h4 ? 32'hFFFF_F9D9 : 32'hFFFF_FA07;
      output_current_abs <= scene == 3'h5 ? 32'h0000_1000 : 32'h0000_0010;
      output_voltage <= 32'h0000_0010;
      thermo_temp <= scene == 3'h7 ? 32'h0000_0200 : 32'h0000_0019;
      fan_ok <= scene == 3'h6 ? 4'hB : 4'hF;
   end
   // Point store: every index gives a distinct value
   assign wave_point = {22'h00_0000, wave_index} + 32'h0000_0A00;
endmodule // fsw_sensor_model

//--- tb_fault_supervisor_waveform.sv
`timescale 1ns/1ns
module tb_fault_supervisor_waveform;
   logic clk_sys = 0, reset = 1, mem_wr = 0, output_current_transducer_ok, output_enable;
   logic wave_cv_mode, wave_step;
   logic [2:0] scene = 0;
   logic [3:0] fan_ok;
   logic [6:0] fault_status;
   logic [7:0] mem_addr = 0;
   logic [9:0] wave_index;
   logic [31:0] mem_wdata = 0, mem_rdata, input_current, output_current_abs, output_voltage;
   logic [31:0] wave_point, wave_setpoint;
   logic signed [31:0] output_power, thermo_temp;
   int fails = 0, compares = 0, cycles = 0;
   fsw_fault_supervisor #(.LONG_CYCLES(40'h00_0000_00C8), .SHORT_CYCLES(32'h0000_0032)) i_dut (
      .clk_sys, .reset, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .input_current,
      .output_current_transducer_ok, .output_power, .output_current_abs, .output_voltage,
      .thermo_temp, .fan_ok, .output_enable, .fault_status, .wave_point, .wave_index,
      .wave_setpoint, .wave_cv_mode, .wave_step);
   fsw_sensor_model i_model (.clk_sys, .scene, .wave_index, .input_current,
      .output_current_transducer_ok, .output_power, .output_current_abs, .output_voltage,
      .thermo_temp, .fan_ok, .wave_point);
   always #2 clk_sys = ~clk_sys;
   // Hang guard, well above the longest expected run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         finish_test;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      mem_wr <= 1'b1;
      mem_addr <= a;
      mem_wdata <= d;
      @(posedge clk_sys);
      mem_wr <= 1'b0;
   endtask
   // Read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      mem_addr <= a;
      cyc(1);
      d = mem_rdata;
   endtask
   task automatic t_regs;
      logic [31:0] d;
      rd(8'h64, d);
      chk("limit reset", 32'hFFFF_FFFF, d);
      wr(8'h64, 32'h0000_0100);
      wr(8'h65, 32'h0000_0100);
      wr(8'h68, 32'h0000_0100);
      rd(8'h65, d);
      chk("volt limit", 32'h0000_0100, d);
      rd(8'h70, d);
      chk("unmapped", 32'h0000_0000, d);
      wr(8'h66, 32'h0000_0001);
      @(posedge clk_sys) scene <= 3'h7;
      cyc(300);
      chk("no fault", 32'h0000_0000, fault_status);
      chk("enable", 32'h0000_0001, output_enable);
      @(posedge clk_sys) scene <= 3'h0;
      $display("test regs done");
   endtask
   // Trip one source, try a reset with the cause present, then clear it
   task automatic t_fault(input logic [2:0] s, input int b, input logic [31:0] c, input int w);
      wr(8'h66, c);
      @(posedge clk_sys) scene <= s;
      if (w > 20) cyc(w - 20);
      if (w > 20) chk("early", 32'h0000_0000, fault_status[b]);
      cyc(w > 20 ? 24 : 3);
      chk("fault bit", 32'h0000_0001, fault_status[b]);
      chk("enable off", 32'h0000_0000, output_enable);
      wr(8'h66, c | 32'h0000_0010);
      cyc(2);
      chk("held", 32'h0000_0001, fault_status[b]);
      @(posedge clk_sys) scene <= 3'h0;
      // Over-power cause lingers one edge while its timer restarts
      cyc(2);
      wr(8'h66, c | 32'h0000_0010);
      cyc(2);
      chk("cleared", 32'h0000_0000, fault_status);
      chk("enable on", 32'h0000_0001, output_enable);
      $display("test fault %0d done", b);
   endtask
   task automatic t_wave;
      logic [31:0] d;
      wr(8'h69, 32'h0000_09C3);
      rd(8'h6B, d);
      chk("reject", 32'h0000_0001, d[8]);
      wr(8'h69, 32'h0000_09C4);
      wr(8'h6A, 32'h0000_0003);
      for (int m = 0; m < 2; m++) begin
         wr(8'h66, 32'h0000_0005 | (m << 3));
         for (int i = 0; i < 3000 && wave_step !== 1'b1; i++) cyc(1);
         chk("step", 32'h0000_0001, wave_step);
         chk("mode", m, wave_cv_mode);
         chk("setpoint", 32'h0000_0A00, wave_setpoint);
         chk("index", 32'h0000_0001, {22'h00_0000, wave_index});
         wr(8'h66, 32'h0000_0000);
         cyc(2600);
      end
      $display("test wave done");
   endtask
   task automatic finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs;
      t_fault(3'h1, 0, 32'h0000_0001, 2);
      t_fault(3'h2, 1, 32'h0000_0001, 2);
      t_fault(3'h3, 2, 32'h0000_0001, 200);
      t_fault(3'h4, 2, 32'h0000_0001, 50);
      t_fault(3'h5, 3, 32'h0000_0001, 2);
      t_fault(3'h6, 6, 32'h0000_0001, 2);
      t_fault(3'h7, 5, 32'h0000_0003, 2);
      t_wave;
      finish_test;
   end
endmodule // tb_fault_supervisor_waveform
